// ==== logic/acr_control.sv ====
// converter control and result registers with settle, gap and oversampling sequencer
// assumes the analog converter answers each sample request with a one-cycle valid
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module acr_control
   import acr_pkg::*;
#(
   parameter int unsigned GAP_UNIT_CYCLES = acr_pkg::ACR_GAP_UNIT_CYC
) (
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   input  wire logic [31:0] reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [15:0] reg_rdata_out,
   input  wire logic        sample_valid_in,
   input  wire logic [9:0]  sample_data_in,
   output logic             regulator_on_out,
   output logic             conv_enable_out,
   output logic             sample_req_out,
   output logic      [2:0]  pos_input_mux_out,
   output logic      [2:0]  neg_input_mux_out,
   output logic      [9:0]  pos_array_offset_out,
   output logic      [9:0]  neg_array_offset_out,
   output logic             pos_offset_active_out,
   output logic             neg_offset_active_out,
   output logic      [2:0]  regulator_level_out,
   output logic      [3:0]  shifter_ref_trim_out,
   output logic             single_ended_out,
   output logic             polarity_out,
   output logic             chopping_out,
   output logic             irq_out
);
   import acr_pkg::*;

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      acr_state_e  state;
      logic [9:0]  cnt;
      logic [7:0]  conv_gap_code;
      logic [7:0]  regulator_settle_count;
      logic [2:0]  pos_input_mux;
      logic [2:0]  neg_input_mux;
      logic [9:0]  pos_array_offset;
      logic [9:0]  neg_array_offset;
      logic [2:0]  regulator_level;
      logic [3:0]  shifter_ref_trim;
      logic        enable;
      logic        conversion_trigger;
      logic        repeat_conversion_flag;
      logic        single_ended_flag;
      logic        polarity_select;
      logic        chopping_flag;
      logic [2:0]  osr;
      logic [1:0]  status;
      logic [1:0]  irq_en;
      logic [16:0] acc;
      logic [7:0]  nsamp;
      logic [15:0] conversion_value;
      logic [15:0] rdata;
      logic        req;
      logic        reg_on;
      logic        conv_en;
      logic        pos_act;
      logic        neg_act;
      logic        irq;
   } acr_state_s;

   acr_state_s  st;
   acr_state_s  next_st;
   logic [2:0]  k_eff;
   logic [7:0]  samp_total;
   logic [9:0]  settle_last;
   logic [16:0] acc_sum;
   logic [22:0] scaled;
   logic        done_evt;
   logic        start_req;
   logic        gap_tick;
   logic        wr_ctl;

   // ***************************************************************
   // helpers
   // ***************************************************************
   // chopping with one sample still takes a pair
   assign k_eff = (st.osr == 3'h0 && st.chopping_flag) ? 3'h1 : st.osr;
   assign samp_total = 8'h01 << k_eff;
   assign settle_last = {st.regulator_settle_count, 2'b00} - 10'h001;
   assign acc_sum = st.acc + {7'h00, sample_data_in};
   // sum of 2^k samples, left aligned; above 64 samples the extra bits stop at six
   assign scaled = {acc_sum, 6'h00} >> k_eff;
   assign done_evt = (st.state == ACR_CONVERT) && sample_valid_in
                     && (st.nsamp == samp_total - 8'h01);
   assign wr_ctl = reg_wr_in && (reg_addr_in == ACR_ADDR_CONTROL);
   // a trigger while busy or not yet settled is ignored
   assign start_req = wr_ctl && reg_wdata_in[ACR_CTL_START]
                      && (st.state == ACR_READY) && !st.conversion_trigger;

   // 1.024 ms unit pulses, restarted when a gap begins
   acr_tick_div #(
      .DIV      (GAP_UNIT_CYCLES)
   ) u_gap_div (
      .mclk_in  (mclk_in),
      .reset_in (reset_in),
      .clear_in (done_evt),
      .tick_out (gap_tick)
   );

   // ***************************************************************
   // next state: register writes first, so sequencer sets win over clears
   // ***************************************************************
   always_comb
   begin
      next_st = st;
      next_st.req = 1'b0;
      next_st.rdata = '0;
      if (reg_wr_in)
      begin
         unique case (reg_addr_in)
            ACR_ADDR_INTERVAL:
            begin
               next_st.conv_gap_code = reg_wdata_in[ACR_GAP_MSB:ACR_GAP_LSB];
               next_st.regulator_settle_count = reg_wdata_in[ACR_DEL_MSB:ACR_DEL_LSB];
            end
            ACR_ADDR_SELECT:
            begin
               next_st.pos_input_mux = reg_wdata_in[ACR_SELP_MSB:ACR_SELP_LSB];
               next_st.neg_input_mux = reg_wdata_in[ACR_SELN_MSB:ACR_SELN_LSB];
            end
            ACR_ADDR_OFFP: next_st.pos_array_offset = reg_wdata_in[ACR_OFF_MSB:0];
            ACR_ADDR_OFFN: next_st.neg_array_offset = reg_wdata_in[ACR_OFF_MSB:0];
            ACR_ADDR_TRIM:
            begin
               next_st.regulator_level = reg_wdata_in[ACR_LVL_MSB:ACR_LVL_LSB];
               next_st.shifter_ref_trim = reg_wdata_in[ACR_SHF_MSB:ACR_SHF_LSB];
            end
            ACR_ADDR_INTCLR: next_st.status[ACR_ST_DONE] = 1'b0;
            ACR_ADDR_CONTROL:
            begin
               next_st.enable = reg_wdata_in[ACR_CTL_ENABLE];
               next_st.repeat_conversion_flag = reg_wdata_in[ACR_CTL_CONT];
               next_st.single_ended_flag = reg_wdata_in[ACR_CTL_SE];
               next_st.polarity_select = reg_wdata_in[ACR_CTL_POL];
               next_st.chopping_flag = reg_wdata_in[ACR_CTL_CHOP];
               next_st.osr = reg_wdata_in[ACR_CTL_OSR_MSB:ACR_CTL_OSR_LSB];
            end
            ACR_ADDR_IRQ_EN: next_st.irq_en = reg_wdata_in[1:0];
            ACR_ADDR_IRQ_CLR: next_st.status = st.status & ~reg_wdata_in[1:0];
            default: ;
         endcase
      end

      // sequencer
      unique case (st.state)
         ACR_OFF:
         begin
            if (st.enable)
            begin
               next_st.state = ACR_SETTLE;
               next_st.cnt = '0;
               next_st.reg_on = 1'b1;
            end
         end
         ACR_SETTLE:
         begin
            next_st.cnt = st.cnt + 10'h001;
            if (st.cnt == settle_last)
            begin
               next_st.state = ACR_READY;
               next_st.conv_en = 1'b1;
               next_st.status[ACR_ST_SETTLED] = 1'b1;
            end
         end
         ACR_READY:
         begin
            if (start_req)
            begin
               next_st.state = ACR_CONVERT;
               next_st.conversion_trigger = 1'b1;
               next_st.req = 1'b1;
               next_st.acc = '0;
               next_st.nsamp = '0;
            end
         end
         ACR_CONVERT:
         begin
            if (done_evt)
            begin
               next_st.conversion_value = scaled[15:0];
               next_st.conversion_trigger = 1'b0;
               next_st.status[ACR_ST_DONE] = 1'b1;
               next_st.acc = '0;
               next_st.nsamp = '0;
               next_st.cnt = '0;
               if (!st.repeat_conversion_flag)
                  next_st.state = ACR_READY;
               else if (st.conv_gap_code == 8'h00)
                  next_st.req = 1'b1;
               else
                  next_st.state = ACR_GAP;
            end
            else if (sample_valid_in)
            begin
               next_st.acc = acc_sum;
               next_st.nsamp = st.nsamp + 8'h01;
               next_st.req = 1'b1;
            end
         end
         ACR_GAP:
         begin
            // clearing continuous mode ends the sequence at the gap
            if (!st.repeat_conversion_flag)
               next_st.state = ACR_READY;
            else if (gap_tick)
            begin
               next_st.cnt = st.cnt + 10'h001;
               // not equal but at least, so a code lowered mid-gap ends it at the next unit
               if (st.cnt[7:0] + 8'h01 >= st.conv_gap_code)
               begin
                  next_st.state = ACR_CONVERT;
                  next_st.req = 1'b1;
               end
            end
         end
      endcase

      // dropping the enable powers down at once and abandons any conversion
      if (!next_st.enable)
      begin
         next_st.state = ACR_OFF;
         next_st.reg_on = 1'b0;
         next_st.conv_en = 1'b0;
         next_st.conversion_trigger = 1'b0;
         next_st.req = 1'b0;
      end

      // trim steering from the polarity and mode bits
      next_st.pos_act = !next_st.single_ended_flag || !next_st.polarity_select
                        || next_st.chopping_flag;
      next_st.neg_act = !next_st.single_ended_flag || next_st.polarity_select
                        || next_st.chopping_flag;
      next_st.irq = |(next_st.status & next_st.irq_en);

      // read data stand only in the cycle after the strobe
      if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            ACR_ADDR_INTERVAL: next_st.rdata = {st.conv_gap_code, st.regulator_settle_count};
            ACR_ADDR_SELECT:
               next_st.rdata = {9'h000, st.pos_input_mux, 1'b0, st.neg_input_mux};
            ACR_ADDR_OFFP: next_st.rdata = {6'h00, st.pos_array_offset};
            ACR_ADDR_OFFN: next_st.rdata = {6'h00, st.neg_array_offset};
            ACR_ADDR_TRIM:
               next_st.rdata = {9'h000, st.regulator_level, st.shifter_ref_trim};
            ACR_ADDR_RESULT: next_st.rdata = st.conversion_value;
            ACR_ADDR_CONTROL:
               next_st.rdata = {7'h00, st.osr, st.chopping_flag, st.polarity_select,
                                st.single_ended_flag, st.repeat_conversion_flag,
                                st.conversion_trigger, st.enable};
            ACR_ADDR_STATUS: next_st.rdata = {14'h0000, st.status};
            ACR_ADDR_IRQ_EN: next_st.rdata = {14'h0000, st.irq_en};
            default: next_st.rdata = '0;
         endcase
      end
   end

   // state register
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         st <= '0;
         st.state <= ACR_OFF;
         st.regulator_settle_count <= ACR_EN_DEL_RST;
         st.pos_array_offset <= ACR_OFF_RST;
         st.neg_array_offset <= ACR_OFF_RST;
         st.regulator_level <= ACR_LVL_RST;
         st.shifter_ref_trim <= ACR_SHF_RST;
         st.pos_act <= 1'b1;
         st.neg_act <= 1'b1;
      end
      else
         st <= next_st;
   end

   // ***************************************************************
   // outputs, all from flip-flops
   // ***************************************************************
   assign reg_rdata_out = st.rdata;
   assign regulator_on_out = st.reg_on;
   assign conv_enable_out = st.conv_en;
   assign sample_req_out = st.req;
   assign pos_input_mux_out = st.pos_input_mux;
   assign neg_input_mux_out = st.neg_input_mux;
   assign pos_array_offset_out = st.pos_array_offset;
   assign neg_array_offset_out = st.neg_array_offset;
   assign pos_offset_active_out = st.pos_act;
   assign neg_offset_active_out = st.neg_act;
   assign regulator_level_out = st.regulator_level;
   assign shifter_ref_trim_out = st.shifter_ref_trim;
   assign single_ended_out = st.single_ended_flag;
   assign polarity_out = st.polarity_select;
   assign chopping_out = st.chopping_flag;
   assign irq_out = st.irq;

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   sequence s_clear_write;
      reg_wr_in && reg_addr_in == ACR_ADDR_INTCLR && !done_evt;
   endsequence
   sequence s_complete;
      done_evt && next_st.enable;
   endsequence

   clear_drops_a: assert property (s_clear_write |=> !st.status[ACR_ST_DONE])
      else $error("done flag survived a clear write");
   clear_reads_a: assert property (reg_rd_in && reg_addr_in == ACR_ADDR_INTCLR
      |=> reg_rdata_out == 16'h0000)
      else $error("clear register read nonzero");
   settle_time_a: assert property ($rose(conv_enable_out)
      |-> $past(st.cnt) == settle_last && $past(st.state) == ACR_SETTLE)
      else $error("converter enabled at wrong settle count");
   pos_trim_a: assert property (pos_offset_active_out == (!single_ended_out
      || !polarity_out || chopping_out))
      else $error("positive trim steering wrong");
   neg_trim_a: assert property (neg_offset_active_out == (!single_ended_out
      || polarity_out || chopping_out))
      else $error("negative trim steering wrong");
   done_flag_a: assert property (s_complete |=> st.status[ACR_ST_DONE]
      && !st.conversion_trigger)
      else $error("completion did not set flag and clear trigger");
   result_hold_a: assert property (!done_evt |=> $stable(st.conversion_value))
      else $error("result changed without a completion");
   single_bits_a: assert property ((s_complete and (k_eff == 3'h0))
      |=> st.conversion_value[5:0] == 6'h00)
      else $error("single sample result has low bits set");
   gap_end_a: assert property (st.state == ACR_GAP && st.repeat_conversion_flag
      && gap_tick && st.cnt[7:0] + 8'h01 == st.conv_gap_code && next_st.enable
      |=> st.state == ACR_CONVERT && sample_req_out)
      else $error("gap did not end at its code");
endmodule // acr_control

// ==== logic/acr_pkg.sv ====
// package of constants, register map and types for the converter control block
// assumes one 20 MHz clock and a plain register port with read data one cycle late
package acr_pkg;
   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int unsigned ACR_CLK_PERIOD_NS = 50;
   localparam int unsigned ACR_GAP_UNIT_NS   = 1024000;  // 1.024 ms
   localparam int unsigned ACR_GAP_UNIT_CYC  = ACR_GAP_UNIT_NS / ACR_CLK_PERIOD_NS;
   localparam int unsigned ACR_SETTLE_SHIFT  = 2;        // four clocks per settle step
   localparam int unsigned ACR_FRAC_BITS     = 6;        // bits below the 10-bit value

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [31:0] ACR_ADDR_INTERVAL = 32'h50001504;
   localparam logic [31:0] ACR_ADDR_SELECT   = 32'h50001506;
   localparam logic [31:0] ACR_ADDR_OFFP     = 32'h50001508;
   localparam logic [31:0] ACR_ADDR_OFFN     = 32'h5000150A;
   localparam logic [31:0] ACR_ADDR_TRIM     = 32'h5000150C;
   localparam logic [31:0] ACR_ADDR_INTCLR   = 32'h5000150E;
   localparam logic [31:0] ACR_ADDR_RESULT   = 32'h50001510;
   localparam logic [31:0] ACR_ADDR_CONTROL  = 32'h50001512;
   localparam logic [31:0] ACR_ADDR_STATUS   = 32'h50001514;
   localparam logic [31:0] ACR_ADDR_IRQ_EN   = 32'h50001516;
   localparam logic [31:0] ACR_ADDR_IRQ_CLR  = 32'h50001518;

   // ***************************************************************
   // fields and reset values
   // ***************************************************************
   localparam int unsigned ACR_GAP_MSB = 15;
   localparam int unsigned ACR_GAP_LSB = 8;
   localparam int unsigned ACR_DEL_MSB = 7;
   localparam int unsigned ACR_DEL_LSB = 0;
   localparam int unsigned ACR_SELP_MSB = 6;
   localparam int unsigned ACR_SELP_LSB = 4;
   localparam int unsigned ACR_SELN_MSB = 2;
   localparam int unsigned ACR_SELN_LSB = 0;
   localparam int unsigned ACR_OFF_MSB = 9;
   localparam int unsigned ACR_LVL_MSB = 6;
   localparam int unsigned ACR_LVL_LSB = 4;
   localparam int unsigned ACR_SHF_MSB = 3;
   localparam int unsigned ACR_SHF_LSB = 0;
   localparam int unsigned ACR_CTL_ENABLE = 0;
   localparam int unsigned ACR_CTL_START  = 1;
   localparam int unsigned ACR_CTL_CONT   = 2;
   localparam int unsigned ACR_CTL_SE     = 3;
   localparam int unsigned ACR_CTL_POL    = 4;
   localparam int unsigned ACR_CTL_CHOP   = 5;
   localparam int unsigned ACR_CTL_OSR_MSB = 8;
   localparam int unsigned ACR_CTL_OSR_LSB = 6;
   localparam int unsigned ACR_ST_DONE    = 0;       // conversion done
   localparam int unsigned ACR_ST_SETTLED = 1;       // regulator settled
   localparam logic [7:0] ACR_EN_DEL_RST  = 8'h40;
   localparam logic [9:0] ACR_OFF_RST     = 10'h200;
   localparam logic [2:0] ACR_LVL_RST     = 3'h3;
   localparam logic [3:0] ACR_SHF_RST     = 4'h8;

   typedef enum logic [2:0] {ACR_OFF, ACR_SETTLE, ACR_READY, ACR_CONVERT, ACR_GAP} acr_state_e;
endpackage

// ==== logic/acr_tick_div.sv ====
// divider giving one-cycle enable pulses at a fixed period
// assumes a clear pulse restarts the period so a gap starts on a whole unit
`timescale 1ns/100ps
module acr_tick_div #(
   parameter int unsigned DIV = 20480
) (
   input  wire logic mclk_in,
   input  wire logic reset_in,
   input  wire logic clear_in,
   output logic      tick_out
);
   localparam int unsigned W = $clog2(DIV + 1);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } acr_div_s;

   acr_div_s st;
   acr_div_s next_st;

   // count up to the period end, pulse, wrap
   always_comb
   begin
      next_st = st;
      next_st.tick = 1'b0;
      if (clear_in)
      begin
         next_st.cnt = '0;
      end
      else if (st.cnt == LAST)
      begin
         next_st.cnt = '0;
         next_st.tick = 1'b1;
      end
      else
      begin
         next_st.cnt = st.cnt + W'(1);
      end
   end

   // state register
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
         st <= '0;
      else
         st <= next_st;
   end

   assign tick_out = st.tick;
endmodule // acr_tick_div

// ==== tb/acr_control_tb.sv ====
// self-checking bench for the converter control and result registers
// assumes one 20 MHz clock, reads answered one cycle late, no stalls
`timescale 1ns/100ps
`define CHK(n, e, g) \
   begin \
      checks_done++; \
      if ((g) !== (e)) \
      begin \
         fail_count++; \
         $display("[ERR] %s exp %h got %h", n, e, g); \
      end \
   end
module acr_control_tb;
   import acr_pkg::*;
   localparam int GAP_CYC = 8;  // short gap unit keeps the run brief
   logic        mclk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic [31:0] reg_addr_in = 32'h0;
   logic [15:0] reg_wdata_in = 16'h0;
   logic        reg_wr_in = 1'b0;
   logic        reg_rd_in = 1'b0;
   logic        sample_valid_in = 1'b0;
   logic [9:0]  sample_data_in = 10'h0;
   logic [15:0] reg_rdata_out;
   logic        regulator_on_out, conv_enable_out, sample_req_out, irq_out;
   logic [2:0]  pos_input_mux_out, neg_input_mux_out, regulator_level_out;
   logic [9:0]  pos_array_offset_out, neg_array_offset_out;
   logic        pos_offset_active_out, neg_offset_active_out;
   logic [3:0]  shifter_ref_trim_out;
   logic        single_ended_out, polarity_out, chopping_out;
   int          fail_count = 0;
   int          checks_done = 0;
   int          seed = 32'h79B66888;
   int          sum, k;
   logic [15:0] last_smp, v;
   logic [31:0] reg_a [8] = '{ACR_ADDR_INTERVAL, ACR_ADDR_SELECT, ACR_ADDR_OFFP, ACR_ADDR_OFFN,
                              ACR_ADDR_TRIM, ACR_ADDR_INTCLR, ACR_ADDR_RESULT, 32'h50001520};
   logic [15:0] rst_v [8] = '{16'h0040, 16'h0000, 16'h0200, 16'h0200,
                              16'h0038, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0] rw_m [5] = '{16'hFFFF, 16'h0077, 16'h03FF, 16'h03FF, 16'h007F};

   acr_control #(.GAP_UNIT_CYCLES(GAP_CYC)) u_dut (
      .mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .sample_valid_in(sample_valid_in),
      .sample_data_in(sample_data_in), .regulator_on_out(regulator_on_out),
      .conv_enable_out(conv_enable_out), .sample_req_out(sample_req_out),
      .pos_input_mux_out(pos_input_mux_out), .neg_input_mux_out(neg_input_mux_out),
      .pos_array_offset_out(pos_array_offset_out),
      .neg_array_offset_out(neg_array_offset_out),
      .pos_offset_active_out(pos_offset_active_out),
      .neg_offset_active_out(neg_offset_active_out),
      .regulator_level_out(regulator_level_out), .shifter_ref_trim_out(shifter_ref_trim_out),
      .single_ended_out(single_ended_out), .polarity_out(polarity_out),
      .chopping_out(chopping_out), .irq_out(irq_out));

   always #25 mclk_in = ~mclk_in;

   // converter stand-in: one random sample the cycle after each request
   always @(posedge mclk_in)
   begin
      sample_valid_in <= sample_req_out;
      if (sample_req_out === 1'b1)
      begin
         last_smp = 16'($random(seed) & 32'h3FF);
         sample_data_in <= last_smp[9:0];
         sum = sum + int'(last_smp);
      end
   end

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge mclk_in);
      reg_wr_in    <= 1'b0;
   endtask

   // read data lives only in the cycle after the strobe, so look there
   task automatic rd_chk(input logic [31:0] a, input logic [15:0] e, input string nm);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge mclk_in);
      reg_rd_in   <= 1'b0;
      #1;
      `CHK(nm, e, reg_rdata_out)
   endtask

   // bounded wait: 0 irq, 1 converter enable, 2 sample request; k counts edges
   task automatic wait_on(input int sel, output int k);
      k = 0;
      do
      begin
         @(posedge mclk_in);
         #1;
         k++;
      end
      while (((sel == 0) ? irq_out : (sel == 1) ? conv_enable_out : sample_req_out) !== 1'b1
             && k < 3000);
      // a wait that runs out is a mismatch
      if (k >= 3000)
         fail_count++;
   endtask

   // one conversion of 2**osr samples, then mask, unmask and clear the interrupt
   // chopping with osr 0 takes a pair of samples, so the sum is halved
   task automatic convert(input int osr, input int chop);
      sum = 0;
      wr(ACR_ADDR_CONTROL, 16'(3 | (chop << 5) | (osr << 6)));
      wait_on(0, k);
      rd_chk(ACR_ADDR_RESULT, 16'((sum << 6) >> ((osr == 0 && chop != 0) ? 1 : osr)),
             "result");
      rd_chk(ACR_ADDR_CONTROL, 16'(1 | (chop << 5) | (osr << 6)), "trigger");
      wr(ACR_ADDR_IRQ_EN, 16'h0000);
      @(posedge mclk_in);
      #1;
      `CHK("irq masked", 1'b0, irq_out)
      wr(ACR_ADDR_IRQ_EN, 16'h0001);
      @(posedge mclk_in);
      #1;
      `CHK("irq raised", 1'b1, irq_out)
      wr(ACR_ADDR_INTCLR, 16'($random(seed)));
      @(posedge mclk_in);
      #1;
      `CHK("irq cleared", 1'b0, irq_out)
      $display("test convert osr %0d done", osr);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // watchdog: the whole sequence needs a few hundred cycles
   initial
   begin
      repeat (40000) @(posedge mclk_in);
      fail_count++;
      test_done;
   end

   initial
   begin
      repeat (6) @(posedge mclk_in);
      reset_in <= 1'b0;
      for (int i = 0; i < 8; i++)
         rd_chk(reg_a[i], rst_v[i], "reset value");
      // random readback; settle code kept nonzero as software must
      for (int j = 0; j < 4; j++)
         for (int i = 0; i < 5; i++)
         begin
            v = 16'($random(seed)) & rw_m[i];
            if (i == 0)
               v[0] = 1'b1;
            wr(reg_a[i], v);
            rd_chk(reg_a[i], v, "readback");
         end
      `CHK("trim out", v[6:0], {regulator_level_out, shifter_ref_trim_out})
      wr(ACR_ADDR_RESULT, 16'hFFFF);
      rd_chk(ACR_ADDR_RESULT, 16'h0000, "result ro");
      rd_chk(ACR_ADDR_INTCLR, 16'h0000, "clear reads");
      for (int i = 0; i < 8; i++)
      begin
         wr(ACR_ADDR_SELECT, 16'((i << 4) | i));
         @(posedge mclk_in);
         #1;
         `CHK("pos mux", 3'(i), pos_input_mux_out)
         `CHK("neg mux", 3'(i), neg_input_mux_out)
      end
      // control bits: bit0 single ended, bit1 polarity, bit2 chopping
      for (int i = 0; i < 8; i++)
      begin
         v = 16'($random(seed)) & 16'h03FF;
         wr(ACR_ADDR_OFFP, v);
         wr(ACR_ADDR_OFFN, v ^ 16'h03FF);
         wr(ACR_ADDR_CONTROL, 16'(i << 3));
         @(posedge mclk_in);
         #1;
         `CHK("pos trim on", !i[0] || !i[1] || i[2], pos_offset_active_out)
         `CHK("neg trim on", !i[0] || i[1] || i[2], neg_offset_active_out)
         `CHK("offp out", v[9:0], pos_array_offset_out)
         `CHK("offn out", v[9:0] ^ 10'h3FF, neg_array_offset_out)
         `CHK("mode bits", 3'(i), {chopping_out, polarity_out, single_ended_out})
      end
      $display("test registers done");
      wr(ACR_ADDR_INTERVAL, 16'h0203);
      wr(ACR_ADDR_IRQ_EN, 16'h0001);
      wr(ACR_ADDR_CONTROL, 16'h0001);
      wait_on(1, k);
      // settle code 3 gives twelve clocks, plus the edge that leaves the off state
      `CHK("settle time", 4 * 3 + 1, k)
      `CHK("regulator on", 1'b1, regulator_on_out)
      convert(0, 0);
      convert(1, 0);
      convert(6, 0);
      convert(0, 1);
      // continuous run: gap of two units, then none
      wr(ACR_ADDR_CONTROL, 16'h0007);
      wait_on(2, k);
      wait_on(2, k);
      `CHK("gap two", 1'b1, k >= 2 * GAP_CYC + 1 && k <= 2 * GAP_CYC + 3)
      repeat (3) @(posedge mclk_in);
      rd_chk(ACR_ADDR_RESULT, last_smp << 6, "repeat result");
      wr(ACR_ADDR_INTERVAL, 16'h0003);
      wait_on(2, k);
      wait_on(2, k);
      `CHK("gap none", 2, k)
      wr(ACR_ADDR_CONTROL, 16'h0000);
      repeat (2) @(posedge mclk_in);
      #1;
      `CHK("abort", 1'b0, conv_enable_out)
      `CHK("regulator off", 1'b0, regulator_on_out)
      $display("test continuous done");
      test_done;
   end
endmodule // acr_control_tb
